// ===== design/bssc_pkg.sv
package bssc_pkg;

  // Position of the scope select bit in its configuration word
  localparam int unsigned BSSC_SCOPE_BIT = 12;
  // Reset values of the two configuration bits
  localparam logic BSSC_SCOPE_RST = 1'h0;
  localparam logic BSSC_OPT_RST = 1'h0;
  // Bus indices
  localparam logic BSSC_BUS_A = 1'h0;
  localparam logic BSSC_BUS_B = 1'h1;
  // Number of input synchroniser stages
  localparam int unsigned BSSC_SYNC_STAGES = 3;

  // Shutdown command presented by the protocol engine
  typedef struct packed {
    logic valid;    // Fully validated mode command, one-cycle pulse
    logic selected; // Selected transmitter shutdown (else plain)
    logic target;   // Bus to shut down (the inactive bus)
    logic restore;  // Override command re-enabling the target bus
  } bssc_cmd_type;

  // Per-bus enables
  typedef struct packed {
    logic tx_en;
    logic rx_en;
  } bssc_bus_en_type;

  // Shutdown state of one bus
  typedef enum logic [2:0] {
    BSSC_ST_ACTIVE = 3'h1,
    BSSC_ST_MUTE = 3'h2,
    BSSC_ST_FULL = 3'h4
  } bssc_state_type;

endpackage

// ===== design/bssc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module bssc_sync
  import bssc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Asynchronous level in, filtered level out
  input wire logic i_async,
  output logic o_level
);

  // Three-stage chain; only stages two and three feed the compare
  logic [BSSC_SYNC_STAGES-1:0] chain_r;

  // Shift chain
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      chain_r <= '0;
    end else begin
      chain_r <= {chain_r[BSSC_SYNC_STAGES-2:0], i_async};
    end
  end

  // Accept a change only when the last two stages agree
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_level <= 1'h0;
    end else if (chain_r[1] == chain_r[2]) begin
      o_level <= chain_r[2];
    end
  end

endmodule
`default_nettype wire

// ===== design/bssc_top.sv
// Function
// - Scope select matters only when option bit low
// - Both low: shutdown kills inactive tx and rx
// - Master reset clears scope and option bits
// - Scope high: kill inactive transmitter only
// - Muted bus still processes and stores commands
// - Muted bus carries no status or data, save a reply asked for in its shutdown cycle
// - Test word flags show automatic shutdown taken
`timescale 1ns/1ps
`default_nettype none
module bssc_top
  import bssc_pkg::*;
(
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_SYS_RST,
  // Configuration from the host, asynchronous pin levels
  input wire logic I_SHUTDOWN_SCOPE_SELECT,
  input wire logic I_MODE_CODE_SHUTDOWN_OPTION,
  input wire logic I_CFG_WE,
  // Mode command from the protocol engine, same clock
  input wire bssc_cmd_type I_CMD,
  // Reply request from the protocol engine, same clock
  input wire logic I_REPLY_REQ,
  input wire logic I_REPLY_BUS,
  // Bus enables
  output logic [1:0] O_TX_EN,
  output logic [1:0] O_RX_EN,
  output logic [1:0] O_RX_PROCESS,
  // Reply gate towards the encoder
  output logic O_REPLY_GO,
  output logic O_REPLY_SUPPRESSED,
  // Built-in test word flags
  output logic [1:0] O_BIT_TX_SHUT,
  output logic [1:0] O_BIT_RX_SHUT,
  // Current configuration as held
  output logic O_SCOPE_SELECT,
  output logic O_SHUTDOWN_OPTION
);

  // Synchronised configuration levels
  logic scope_sync;
  logic opt_sync;
  logic we_sync;
  // Previous write-enable level for edge detection
  logic we_prev_r;
  // Held configuration bits
  // Option high hands the shutdown decision back to the host
  logic scope_r;
  logic opt_r;
  // Per-bus shutdown state
  // One-hot code per bus; index 0 is bus A, index 1 is bus B
  bssc_state_type state_r [2];
  bssc_state_type state_nxt [2];

  // Pins come from the host domain and need filtering
  // A pin may change at any time against the core clock, so each one
  // passes its own filter; the strobe is filtered the same way so it
  // cannot overtake the levels that it qualifies
  bssc_sync u_sync_scope (
    .i_clk(I_CORE_CLK),
    .i_rst(I_SYS_RST),
    .i_async(I_SHUTDOWN_SCOPE_SELECT),
    .o_level(scope_sync)
  );
  bssc_sync u_sync_opt (
    .i_clk(I_CORE_CLK),
    .i_rst(I_SYS_RST),
    .i_async(I_MODE_CODE_SHUTDOWN_OPTION),
    .o_level(opt_sync)
  );
  bssc_sync u_sync_we (
    .i_clk(I_CORE_CLK),
    .i_rst(I_SYS_RST),
    .i_async(I_CFG_WE),
    .o_level(we_sync)
  );

  // Write-enable edge tracker
  // Resets low, the idle level of the strobe pin, so that no false
  // load edge follows reset
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      we_prev_r <= 1'h0;
    end else begin
      we_prev_r <= we_sync;
    end
  end

  // Configuration bits, loaded on a write-enable rising edge
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      scope_r <= BSSC_SCOPE_RST;
      opt_r <= BSSC_OPT_RST;
    end else if (we_sync && !we_prev_r) begin
      // Scope stays as written; low is the advised setting
      scope_r <= scope_sync;
      opt_r <= opt_sync;
    end
  end

  // Next state per bus
  for (genvar b = 0; b < 2; b++) begin : g_next
    always_comb begin
      state_nxt[b] = state_r[b];
      // Only a validated command for this bus changes anything
      // Plain and selected shutdown are treated alike here; the engine
      // has already decided that this bus is the inactive one
      if (I_CMD.valid && (I_CMD.target == 1'(b))) begin
        if (I_CMD.restore) begin
          // Override command brings the bus back
          state_nxt[b] = BSSC_ST_ACTIVE;
        end else if (!opt_r) begin
          // Automatic shutdown only with option low
          if (scope_r) begin
            state_nxt[b] = BSSC_ST_MUTE;
          end else begin
            state_nxt[b] = BSSC_ST_FULL;
          end
        end
        // Option high leaves the action to the host
      end
    end
  end

  // Shutdown state, held until reset or a later command
  // A restore command is the only way back to active besides reset
  for (genvar b = 0; b < 2; b++) begin : g_state
    always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
        state_r[b] <= BSSC_ST_ACTIVE;
      end else begin
        state_r[b] <= state_nxt[b];
      end
    end
  end

  // Bus enables and test word flags, registered per bus
  // Driven from the next state so they move at the edge that takes
  // the command; the cost is a deeper cone in front of each flop
  for (genvar b = 0; b < 2; b++) begin : g_out
    always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
        O_TX_EN[b] <= 1'h1;
        O_RX_EN[b] <= 1'h1;
        O_RX_PROCESS[b] <= 1'h1;
        O_BIT_TX_SHUT[b] <= 1'h0;
        O_BIT_RX_SHUT[b] <= 1'h0;
      end else begin
        case (state_nxt[b])
          BSSC_ST_ACTIVE: begin
            O_TX_EN[b] <= 1'h1;
            O_RX_EN[b] <= 1'h1;
            O_RX_PROCESS[b] <= 1'h1;
            O_BIT_TX_SHUT[b] <= 1'h0;
            O_BIT_RX_SHUT[b] <= 1'h0;
          end
          BSSC_ST_MUTE: begin
            // Receiver keeps decoding and storing data
            O_TX_EN[b] <= 1'h0;
            O_RX_EN[b] <= 1'h1;
            O_RX_PROCESS[b] <= 1'h1;
            O_BIT_TX_SHUT[b] <= 1'h1;
            O_BIT_RX_SHUT[b] <= 1'h0;
          end
          BSSC_ST_FULL: begin
            O_TX_EN[b] <= 1'h0;
            O_RX_EN[b] <= 1'h0;
            O_RX_PROCESS[b] <= 1'h0;
            O_BIT_TX_SHUT[b] <= 1'h1;
            O_BIT_RX_SHUT[b] <= 1'h1;
          end
          default: begin
            // Illegal code: fail safe to full shutdown
            O_TX_EN[b] <= 1'h0;
            O_RX_EN[b] <= 1'h0;
            O_RX_PROCESS[b] <= 1'h0;
            O_BIT_TX_SHUT[b] <= 1'h1;
            O_BIT_RX_SHUT[b] <= 1'h1;
          end
        endcase
      end
    end
  end

  // Reply gate: a muted bus carries neither status nor data
  // Limitation: a reply asked for in the very cycle of a shutdown still
  // passes if the bus was active then; the engine never overlaps them
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      O_REPLY_GO <= 1'h0;
      O_REPLY_SUPPRESSED <= 1'h0;
    end else if (I_REPLY_REQ) begin
      // Uses current state so a same-cycle command affects later replies
      if (state_r[I_REPLY_BUS] == BSSC_ST_ACTIVE) begin
        O_REPLY_GO <= 1'h1;
        O_REPLY_SUPPRESSED <= 1'h0;
      end else begin
        O_REPLY_GO <= 1'h0;
        O_REPLY_SUPPRESSED <= 1'h1;
      end
    end else begin
      O_REPLY_GO <= 1'h0;
      O_REPLY_SUPPRESSED <= 1'h0;
    end
  end

  // Mirror of held configuration
  // Lets the host read back what was loaded, one cycle behind the load
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      O_SCOPE_SELECT <= BSSC_SCOPE_RST;
      O_SHUTDOWN_OPTION <= BSSC_OPT_RST;
    end else begin
      O_SCOPE_SELECT <= scope_r;
      O_SHUTDOWN_OPTION <= opt_r;
    end
  end

endmodule
`default_nettype wire

// ===== dv/bssc_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Ties enables, flags and reply gate to the command that caused them
module bssc_top_properties
  import bssc_pkg::*;
(
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_SYS_RST,
  // Stimulus side
  input wire bssc_cmd_type I_CMD,
  input wire logic I_REPLY_REQ,
  input wire logic I_REPLY_BUS,
  // Observed outputs
  input wire logic [1:0] O_TX_EN,
  input wire logic [1:0] O_RX_EN,
  input wire logic [1:0] O_RX_PROCESS,
  input wire logic O_REPLY_GO,
  input wire logic O_REPLY_SUPPRESSED,
  input wire logic [1:0] O_BIT_TX_SHUT,
  input wire logic [1:0] O_BIT_RX_SHUT,
  input wire logic O_SCOPE_SELECT,
  input wire logic O_SHUTDOWN_OPTION
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SYS_RST);
  // Automatic shutdown request taken at this edge
  logic kill;
  logic tgt_r;
  assign kill = I_CMD.valid && !I_CMD.restore && !O_SHUTDOWN_OPTION;
  // Target of the previous edge, so the consequent can index it
  always_ff @(posedge I_CORE_CLK) begin
    tgt_r <= I_CMD.target;
  end
  AST_FULL: assert property (kill && !O_SCOPE_SELECT |=> !O_TX_EN[tgt_r] &&
    !O_RX_EN[tgt_r] && O_BIT_RX_SHUT[tgt_r]) else $error("full shutdown missed");
  AST_MUTE: assert property (kill && O_SCOPE_SELECT && O_RX_EN[I_CMD.target]
    |=> !O_TX_EN[tgt_r] && O_RX_EN[tgt_r] && O_BIT_TX_SHUT[tgt_r])
    else $error("mute shutdown wrong");
  AST_OPT_OFF: assert property (I_CMD.valid && !I_CMD.restore &&
    O_SHUTDOWN_OPTION |=> $stable(O_TX_EN) && $stable(O_RX_EN))
    else $error("shutdown acted while option set");
  AST_RESTORE: assert property (I_CMD.valid && I_CMD.restore |=>
    O_TX_EN[tgt_r] && O_RX_EN[tgt_r]) else $error("restore failed");
  AST_HOLD: assert property (!I_CMD.valid |=> $stable(O_TX_EN) &&
    $stable(O_RX_EN)) else $error("enables moved without command");
  AST_GO: assert property (I_REPLY_REQ && O_TX_EN[I_REPLY_BUS] |=>
    O_REPLY_GO && !O_REPLY_SUPPRESSED) else $error("reply not let through");
  AST_MUTED: assert property (I_REPLY_REQ && !O_TX_EN[I_REPLY_BUS] |=>
    !O_REPLY_GO && O_REPLY_SUPPRESSED) else $error("reply on muted bus");
  AST_PROC: assert property (O_RX_PROCESS == O_RX_EN)
    else $error("processing differs from receiver");
  AST_RST: assert property (disable iff (1'b0) I_SYS_RST |=>
    O_TX_EN == 2'h3 && !O_SCOPE_SELECT && !O_SHUTDOWN_OPTION)
    else $error("reset values wrong");
endmodule
bind bssc_top bssc_top_properties i_props (
  .I_CORE_CLK(I_CORE_CLK), .I_SYS_RST(I_SYS_RST), .I_CMD(I_CMD),
  .I_REPLY_REQ(I_REPLY_REQ), .I_REPLY_BUS(I_REPLY_BUS), .O_TX_EN(O_TX_EN),
  .O_RX_EN(O_RX_EN), .O_RX_PROCESS(O_RX_PROCESS), .O_REPLY_GO(O_REPLY_GO),
  .O_REPLY_SUPPRESSED(O_REPLY_SUPPRESSED), .O_BIT_TX_SHUT(O_BIT_TX_SHUT),
  .O_BIT_RX_SHUT(O_BIT_RX_SHUT), .O_SCOPE_SELECT(O_SCOPE_SELECT),
  .O_SHUTDOWN_OPTION(O_SHUTDOWN_OPTION));
`default_nettype wire

// ===== dv/bssc_engine.sv
`timescale 1ns/1ps
`default_nettype none
// Protocol engine stand-in: one-cycle command and reply pulses
module bssc_engine
  import bssc_pkg::*;
(
  input wire logic i_clk,
  output var bssc_cmd_type o_cmd,
  output logic o_req,
  output logic o_bus
);
  initial begin
    o_cmd = '0;
    o_req = 1'h0;
    o_bus = 1'h0;
  end
  // Validated command, held for exactly one edge
  task automatic send_cmd(input logic t, input logic r, input logic s);
    @(negedge i_clk);
    o_cmd = '{valid:1'h1, selected:s, target:t, restore:r};
    @(negedge i_clk);
    o_cmd.valid = 1'h0;
  endtask
  // Reply request; bus line flips afterwards so nothing stale lingers
  task automatic send_reply(input logic b);
    @(negedge i_clk);
    o_req = 1'h1;
    o_bus = b;
    @(negedge i_clk);
    o_req = 1'h0;
    o_bus = ~b;
  endtask
endmodule
`default_nettype wire

// ===== dv/bssc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bssc_top_tb
  import bssc_pkg::*;
  ;
  logic clk, rst, scope, opt, we, req, bus, go, sup, cs, co, t, r;
  bssc_cmd_type cmd;
  logic [1:0] tx_en, rx_en, rx_proc, btx, brx, etx, erx;
  logic [31:0] rv;
  int num_errors, num_checks, cyc, seed;
  bssc_engine eng (.i_clk(clk), .o_cmd(cmd), .o_req(req), .o_bus(bus));
  bssc_top i_dut (.I_CORE_CLK(clk), .I_SYS_RST(rst),
    .I_SHUTDOWN_SCOPE_SELECT(scope), .I_MODE_CODE_SHUTDOWN_OPTION(opt),
    .I_CFG_WE(we), .I_CMD(cmd), .I_REPLY_REQ(req), .I_REPLY_BUS(bus),
    .O_TX_EN(tx_en), .O_RX_EN(rx_en), .O_RX_PROCESS(rx_proc),
    .O_REPLY_GO(go), .O_REPLY_SUPPRESSED(sup), .O_BIT_TX_SHUT(btx),
    .O_BIT_RX_SHUT(brx), .O_SCOPE_SELECT(cs), .O_SHUTDOWN_OPTION(co));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // Expected enable after a command: restore wins, else kept or killed
  function automatic logic step(logic cur, logic rs, logic keep);
    return rs | (keep & cur);
  endfunction
  task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Pins settle well before and through the load strobe
  task automatic set_cfg(input logic s, input logic o);
    scope = s;
    opt = o;
    repeat (6) @(negedge clk);
    we = 1'h1;
    repeat (8) @(negedge clk);
    we = 1'h0;
    repeat (6) @(negedge clk);
  endtask
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    seed = 71;
    rst = 1'h1;
    {scope, opt, we} = 3'h0;
    repeat (5) @(negedge clk);
    rst = 1'h0;
    etx = 2'h3;
    erx = 2'h3;
    chk(tx_en & rx_en, etx);
    chk({cs, co}, 2'h0);
    // Default full shutdown first, as a host normally keeps it
    for (int p = 0; p < 4; p++) begin
      set_cfg(p[0], p[1]);
      // Scope select is p[0] and the option bit is p[1]
      chk({cs, co}, {p[0], p[1]});
      for (int k = 0; k < 24; k++) begin
        rv = $random(seed);
        t = (k < 2) ? k[0] : rv[0];
        r = (k < 2) || (rv[3:1] == 3'h0);
        eng.send_cmd(t, r, rv[4]);
        etx[t] = step(etx[t], r, p[1]);
        erx[t] = step(erx[t], r, p[1] | p[0]);
        chk(tx_en, etx);
        chk(rx_en, erx);
        chk(rx_proc, erx);
        // Flags track the shutdown held, restores included
        chk(btx, ~etx);
        chk(brx, ~erx);
        if (!r && !p[1]) chk({btx[t], brx[t]}, {1'h1, !p[0]});
        eng.send_reply(rv[5]);
        chk({go, sup}, {etx[rv[5]], !etx[rv[5]]});
      end
    end
    complete_run();
  end
endmodule
`default_nettype wire
